// ===== core/ptb_defines.vh
// Purpose: Constants for the periodic tick unit
// Assumes: Included by the design file and the testbench
// Notes: Byte offsets on a 32-bit AXI4-Lite slave
`ifndef PTB_DEFINES_VH
`define PTB_DEFINES_VH

// ==========================================================
// Register map
`define PTB_ADDR_W 4
`define PTB_OFF_CTRL 4'h0
`define PTB_OFF_STAT 4'h4
`define PTB_OFF_MASK 4'h8

// ==========================================================
// Control register fields, then the status and mask bit
`define PTB_BIT_EN 1
`define PTB_BIT_IE 2
`define PTB_BIT_ACK 3
`define PTB_RATE_LO 4
`define PTB_RATE_HI 6
`define PTB_BIT_FLAG 7
`define PTB_BIT_STAT 0

// ==========================================================
// Reset values
`define PTB_RST_CTRL 8'h00
`define PTB_RST_MASK 1'b1

// ==========================================================
// Divider taps (bit whose rise marks rollover)
`define PTB_TAP_0 4'hE
`define PTB_TAP_1 4'hC
`define PTB_TAP_2 4'hA
`define PTB_TAP_3 4'h6
`define PTB_TAP_4 4'h5
`define PTB_TAP_5 4'h4
`define PTB_TAP_6 4'h3
`define PTB_TAP_7 4'h2

// ==========================================================
// Bus answers and clocks
`define PTB_RESP_OKAY 2'h0
`define PTB_RESP_SLVERR 2'h2
`define PTB_XTAL_HZ 32768
`define PTB_ACLK_HZ 20000000

`endif

// ===== core/ptb_periodic_tick_unit.v
// Purpose: Periodic wake-up tick and interrupt from a crystal divider
// Assumes: crystal_ref_clock far slower than aclk, sampled as a pin
// Notes: Single clock domain; crystal edges become enable pulses
//
// Contract
// - Fifteen-stage divider, eight selectable rollover taps
// - Divider advances on rising crystal reference clock edges
// - Enable cleared holds divider at zero
// - Counting starts once enable is set
// - Tap rollover sets pending flag; not writable
// - Flag plus interrupt enable raises request; the code also needs the mask register bit set
// - First flag at half period, then full
// - Rate field picks divider 32768 down to 8
// - Acknowledge write-only, reads zero, one clears
// - Reset clears enable and interrupt enable
// - Wait mode: counts, register not accessible
// - Stop mode counts only when oscillator kept
// - Stop without oscillator idles; register inaccessible
//
// Our own choices: the register addresses and the AXI4-Lite slave port.
`include "ptb_defines.vh"

module ptb_periodic_tick_unit #(
  parameter CNT_W = 15
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Crystal and power modes
  input wire crystal_ref_clock,
  input wire wait_mode,
  input wire stop_mode,
  input wire osc_run_in_stop,
  // AXI4-Lite write address
  input wire [`PTB_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [`PTB_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Interrupt
  output reg irq
);

  // ==========================================================
  // Tap decode
  function [3:0] tap_of;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tap_of = `PTB_TAP_0;
        3'h1: tap_of = `PTB_TAP_1;
        3'h2: tap_of = `PTB_TAP_2;
        3'h3: tap_of = `PTB_TAP_3;
        3'h4: tap_of = `PTB_TAP_4;
        3'h5: tap_of = `PTB_TAP_5;
        3'h6: tap_of = `PTB_TAP_6;
        default: tap_of = `PTB_TAP_7;
      endcase
    end
  endfunction

  // ==========================================================
  // Address decode, shared by the write and read paths
  function reg_mapped;
    input [`PTB_ADDR_W-1:0] addr;
    begin
      reg_mapped = (addr == `PTB_OFF_CTRL) | (addr == `PTB_OFF_STAT) |
                   (addr == `PTB_OFF_MASK);
    end
  endfunction

  // ==========================================================
  // State
  reg tick_enable_reg;
  reg tick_irq_enable_reg;
  reg [2:0] tick_rate_select_reg;
  reg tick_pending_flag_reg;
  reg irq_mask_reg;
  reg [CNT_W-1:0] cnt_reg;
  reg xs1_reg;
  reg xs2_reg;
  reg xs3_reg;
  reg aw_got_reg;
  reg w_got_reg;
  reg [`PTB_ADDR_W-1:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;

  // ==========================================================
  // Crystal edge as an enable pulse
  // Two flops first: the crystal is asynchronous to aclk
  // Third flop only remembers the last level for edge detection
  always @(posedge aclk) begin
    if (!aresetn) begin
      xs1_reg <= 1'b0;
      xs2_reg <= 1'b0;
      xs3_reg <= 1'b0;
    end else begin
      xs1_reg <= crystal_ref_clock;
      xs2_reg <= xs1_reg;
      xs3_reg <= xs2_reg;
    end
  end

  wire xtal_edge = xs2_reg & ~xs3_reg;
  // Stop without the oscillator freezes the chain
  wire osc_alive = ~stop_mode | osc_run_in_stop;
  wire advance = xtal_edge & tick_enable_reg & osc_alive;
  wire [CNT_W-1:0] cnt_inc = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [CNT_W-1:0] rise_bits = cnt_inc & ~cnt_reg;
  // Tap bit rises after half its period first, then every period
  // Rate changes while enabled can miss or double a tick
  wire tick_set = advance &
    rise_bits[tap_of(tick_rate_select_reg)];

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (!tick_enable_reg) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (advance) begin
      cnt_reg <= cnt_inc;
    end
  end

  // ==========================================================
  // Register bus
  // Low-power modes lock software out; bus still answers
  wire bus_open = ~wait_mode & ~stop_mode;
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_got_reg | aw_hs;
  wire w_have = w_got_reg | w_hs;
  wire [`PTB_ADDR_W-1:0] wa = aw_hs ? s_axi_awaddr : awaddr_reg;
  wire [31:0] wd = w_hs ? s_axi_wdata : wdata_reg;
  wire [3:0] ws = w_hs ? s_axi_wstrb : wstrb_reg;
  wire do_write = aw_have & w_have & ~s_axi_bvalid;
  // Protection bits and upper strobe lanes carry no meaning here
  wire wr_ok = do_write & bus_open & ws[0];
  wire wr_ctrl = wr_ok & (wa == `PTB_OFF_CTRL);
  wire wr_stat = wr_ok & (wa == `PTB_OFF_STAT);
  wire wr_mask = wr_ok & (wa == `PTB_OFF_MASK);
  wire wa_mapped = reg_mapped(wa);
  wire flag_clr = (wr_ctrl & wd[`PTB_BIT_ACK]) |
                  (wr_stat & wd[`PTB_BIT_STAT]);

  // ==========================================================
  // Write handshake
  // Hold what arrived first until its partner channel shows up
  always @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_reg <= {`PTB_ADDR_W{1'b0}};
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_hs) begin
        awaddr_reg <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTB_RESP_OKAY;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
    end else begin
      if (do_write) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_mapped ? `PTB_RESP_OKAY : `PTB_RESP_SLVERR;
      end else begin
        if (aw_hs) begin
          aw_got_reg <= 1'b1;
          s_axi_awready <= 1'b0;
        end
        if (w_hs) begin
          w_got_reg <= 1'b1;
          s_axi_wready <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
          s_axi_awready <= 1'b1;
          s_axi_wready <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Control, flag and mask
  // Reset image of the control byte, taken apart per field
  wire [7:0] rst_ctrl = `PTB_RST_CTRL;

  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_enable_reg <= rst_ctrl[`PTB_BIT_EN];
      tick_irq_enable_reg <= rst_ctrl[`PTB_BIT_IE];
      tick_rate_select_reg <= rst_ctrl[`PTB_RATE_HI:`PTB_RATE_LO];
    end else if (wr_ctrl) begin
      tick_enable_reg <= wd[`PTB_BIT_EN];
      tick_irq_enable_reg <= wd[`PTB_BIT_IE];
      tick_rate_select_reg <= wd[`PTB_RATE_HI:`PTB_RATE_LO];
    end
  end

  // Set beats clear in the same cycle, so no tick is lost to a clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_pending_flag_reg <= 1'b0;
    end else begin
      tick_pending_flag_reg <= tick_set |
        (tick_pending_flag_reg & ~flag_clr);
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_reg <= `PTB_RST_MASK;
    end else if (wr_mask) begin
      irq_mask_reg <= wd[`PTB_BIT_STAT];
    end
  end

  // Registered for a clean pin; follows the flag one cycle late
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= tick_pending_flag_reg & tick_irq_enable_reg &
             irq_mask_reg;
    end
  end

  // ==========================================================
  // Read path
  reg [31:0] rd_val;
  wire rd_hit = reg_mapped(s_axi_araddr);
  always @* begin
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `PTB_OFF_CTRL: begin
        rd_val[`PTB_BIT_FLAG] = tick_pending_flag_reg;
        rd_val[`PTB_RATE_HI:`PTB_RATE_LO] = tick_rate_select_reg;
        rd_val[`PTB_BIT_IE] = tick_irq_enable_reg;
        rd_val[`PTB_BIT_EN] = tick_enable_reg;
      end
      `PTB_OFF_STAT: rd_val[`PTB_BIT_STAT] = tick_pending_flag_reg;
      `PTB_OFF_MASK: rd_val[`PTB_BIT_STAT] = irq_mask_reg;
      default: rd_val = 32'h00000000;
    endcase
    if (!bus_open) begin
      rd_val = 32'h00000000;
    end
  end

  // One read in flight; arready returns with the R handshake
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PTB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `PTB_RESP_OKAY : `PTB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// ===== tb/ptb_tick_sva.sv
// Purpose: Bus and tick assertions
// Assumes: Control at 0, 4'hC unmapped
// Notes: Bound to the top ports only
module ptb_tick_sva (
  // Clock, modes, irq
  input wire aclk, aresetn, wait_mode, stop_mode, irq,
  // Bus
  input wire [3:0] s_axi_awaddr, s_axi_araddr,
  input wire [31:0] s_axi_wdata, s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire ar = s_axi_arvalid && s_axi_arready;
  wire lck = wait_mode || stop_mode;
  // =====
  // Bus handshakes
  a_write_resp: assert property (aw |=> s_axi_bvalid)
    else $error("late write response");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (ar |=> s_axi_rvalid)
    else $error("late read data");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_unmapped_err: assert property (ar && s_axi_araddr == 4'hC |=>
    s_axi_rresp == 2'h2) else $error("unmapped read not refused");
  // =====
  // Register rules
  a_read_zero: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0 && !s_axi_rdata[3]) else $error("bad bits");
  a_locked_read: assert property (ar && lck |=>
    s_axi_rdata == 32'h0) else $error("register readable in low power");
  a_ack_clears: assert property (aw && s_axi_awaddr == 4'h0 &&
    s_axi_wdata[3] && !lck |-> ##[3:4] !irq) else $error("ack ignored");
  c_irq: cover property ($rose(irq));
  c_locked: cover property (ar && lck);
  c_unmapped: cover property (ar && s_axi_araddr == 4'hC);
endmodule

bind ptb_periodic_tick_unit ptb_tick_sva u_chk (.aclk, .aresetn,
  .wait_mode, .stop_mode, .irq, .s_axi_awaddr, .s_axi_araddr,
  .s_axi_wdata, .s_axi_rdata, .s_axi_rresp, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);

// ===== tb/tb_periodic_timebase.sv
// Purpose: Self-checking bench for the tick unit
// Assumes: Crystal period of eight aclk cycles
// Notes: Rates 0..2 skipped to keep the run short
`include "ptb_defines.vh"
module tb_periodic_timebase;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, crystal_ref_clock = 0, irq;
  logic wait_mode = 0, stop_mode = 0, osc_run_in_stop = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_bvalid, s_axi_rvalid;
  logic s_axi_awready, s_axi_wready, s_axi_arready;
  logic [3:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
  logic [1:0] s_axi_rresp, rs;
  int errors = 0, num_checks = 0, cyc = 0, t0, t1, t2;
  logic [2:0] rate_t [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
  int div_t [5] = '{8, 16, 32, 64, 128};
  logic [1:0] xdiv = '0;

  ptb_periodic_tick_unit u_ptb_periodic_tick_unit (.aclk, .aresetn,
    .crystal_ref_clock, .wait_mode, .stop_mode, .osc_run_in_stop,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp(), .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq);

  initial forever #25 aclk = ~aclk;
  // Crystal at one eighth of aclk, driven like any other input
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    xdiv <= xdiv + 2'h1;
    if (xdiv == 2'h3) crystal_ref_clock <= ~crystal_ref_clock;
    if (cyc == 20000) begin
      errors++;
      final_report();
    end
  end

  // =====
  // Bus and check tasks
  task chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    bit dn;
    dn = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        dn = 1;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task rd(input logic [3:0] a);
    bit dn;
    dn = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!dn) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        dn = 1;
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  task rc(input string n, input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(n, v, e);
  endtask
  // Waits out a standing request, then the next rise
  task wirq(output int t);
    while (irq === 1'b1) @(posedge aclk);
    do @(posedge aclk); while (irq !== 1'b1);
    t = cyc;
  endtask
  task final_report;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // =====
  // Main sequence
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      wr(`PTB_OFF_CTRL, 32'h0);
      wr(`PTB_OFF_CTRL, {25'h0, rate_t[i], 4'hE});
      t0 = cyc;
      wirq(t1);
      // Half a period of crystal edges, give or take one crystal cycle
      t2 = t1 - t0 - div_t[i] * 4;
      chk("first", t2 >= -8 && t2 <= 8, 1);
      wr(`PTB_OFF_CTRL, {25'h0, rate_t[i], 4'hE});
      wirq(t2);
      chk("period", t2 - t1, div_t[i] * 8);
    end
    $display("rate rows done");
    wr(`PTB_OFF_CTRL, 32'h04);
    rc("ctrl", `PTB_OFF_CTRL, 32'h84);
    wr(`PTB_OFF_MASK, 32'h0);
    repeat (2) @(posedge aclk);
    chk("irq_masked", irq, 0);
    wr(`PTB_OFF_MASK, 32'h1);
    repeat (2) @(posedge aclk);
    chk("irq_on", irq, 1);
    wr(`PTB_OFF_STAT, 32'h1);
    rc("stat", `PTB_OFF_STAT, 32'h0);
    wr(`PTB_OFF_CTRL, 32'h80);
    repeat (200) @(posedge aclk);
    rc("no_set", `PTB_OFF_CTRL, 32'h0);
    wr(`PTB_OFF_CTRL, 32'h7E);
    wait_mode <= 1'b1;
    rc("locked", `PTB_OFF_CTRL, 32'h0);
    wirq(t1);
    wr(`PTB_OFF_CTRL, 32'h7E);
    repeat (2) @(posedge aclk);
    chk("wait_irq", irq, 1);
    wait_mode <= 1'b0;
    wr(`PTB_OFF_CTRL, 32'h7E);
    stop_mode <= 1'b1;
    repeat (300) @(posedge aclk);
    chk("stop_frozen", irq, 0);
    osc_run_in_stop <= 1'b1;
    wirq(t1);
    stop_mode <= 1'b0;
    rd(4'hC);
    chk("unmapped", rs, `PTB_RESP_SLVERR);
    wr(`PTB_OFF_CTRL, 32'h0C);
    stop_mode <= 1'b1;
    repeat (100) @(posedge aclk);
    chk("stop_idle", irq, 0);
    stop_mode <= 1'b0;
    $display("mode tests done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc("ctrl_rst", `PTB_OFF_CTRL, 32'h0);
    rc("mask_rst", `PTB_OFF_MASK, 32'h1);
    $display("reset tests done");
    final_report();
  end
endmodule
